// >>> sbr_baud_gen.sv
// register file on the bus and rate selection of the serial baud rate generator
//
// Operation
// - one divider timer gives the bit rate for asynchronous and synchronous modes.
// - after reset the timer counts eight bits until wide select is set.
// - wide select set makes a sixteen bit count from both divisor bytes.
// - timer runs continuously with period given by divisor value n and the multiplier.
// - asynchronous multiplier is chosen by high speed and wide select together.
// - synchronous mode ignores the high speed select bit.
// - writing either divisor byte clears the timer on the cycle after the registered clear is set.
// - divisor value n is the low byte, or the high and low byte pair when wide select is set.
// - asynchronous, narrow, normal speed: rate is clock over 64 times n+1.
// - asynchronous, wide, normal speed: rate is clock over 16 times n+1.
// - synchronous, narrow: rate is clock over 4 times n+1, any speed bit.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sbr_baud_gen (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register bus
    input wire sbr_pkg::sbr_axi_req_t s_axi_req,
    output logic [$bits(sbr_pkg::sbr_axi_rsp_t)-1:0] s_axi_rsp,
    // transceiver side
    input wire logic receiver_idle,
    output logic bit_tick,
    output logic sync_select
);

    typedef struct packed {
        sbr_pkg::sbr_axi_rsp_t rsp;
        logic aw_held;
        logic [31:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wide;
        logic sync;
        logic high_speed;
        logic [7:0] div_low;
        logic [7:0] div_high;
        logic clear;
    } sbr_state_t;

    sbr_state_t state;
    sbr_state_t next_state;
    sbr_pkg::sbr_rate_cfg_t cfg;
    logic wr_fire;
    logic wr_divisor;
    logic wr_known;
    logic [7:0] wr_byte;
    logic rd_fire;
    logic rd_known;
    logic [7:0] rd_byte;

    ////////////////////////////////////////////////////////////////////////////
    // write address decode
    always_comb begin
        wr_fire = state.aw_held && state.w_held && !state.rsp.bvalid;
        wr_byte = state.wdata[7:0];
        wr_known = 1'b1;
        wr_divisor = 1'b0;
        unique case (state.awaddr)
            sbr_pkg::BAUD_CONTROL_1_ADDR: begin
                wr_divisor = 1'b0;
            end
            sbr_pkg::TRANSMIT_STATUS_CONTROL_1_ADDR: begin
                wr_divisor = 1'b0;
            end
            sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR: begin
                wr_divisor = 1'b1;
            end
            sbr_pkg::DIVISOR_HIGH_BYTE_1_ADDR: begin
                wr_divisor = 1'b1;
            end
            default: begin
                wr_known = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // read address decode; unused bits read as zero
    always_comb begin
        rd_fire = s_axi_req.arvalid && state.rsp.arready;
        rd_byte = sbr_pkg::READ_ZERO;
        rd_known = 1'b1;
        unique case (s_axi_req.araddr)
            sbr_pkg::BAUD_CONTROL_1_ADDR: begin
                // software polls this before a system clock change
                rd_byte[sbr_pkg::RECEIVER_IDLE_BIT] = receiver_idle;
                rd_byte[sbr_pkg::WIDE_DIVIDER_BIT] = state.wide;
            end
            sbr_pkg::TRANSMIT_STATUS_CONTROL_1_ADDR: begin
                rd_byte[sbr_pkg::SYNC_SELECT_BIT] = state.sync;
                rd_byte[sbr_pkg::HIGH_SPEED_BIT] = state.high_speed;
            end
            sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR: begin
                rd_byte = state.div_low;
            end
            sbr_pkg::DIVISOR_HIGH_BYTE_1_ADDR: begin
                rd_byte = state.div_high;
            end
            default: begin
                rd_known = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes and register updates
    always_comb begin
        next_state = state;
        next_state.clear = 1'b0;
        // address and data are taken independently, in either order
        if (s_axi_req.awvalid && state.rsp.awready) begin
            next_state.aw_held = 1'b1;
            next_state.awaddr = s_axi_req.awaddr;
            next_state.rsp.awready = 1'b0;
        end
        if (s_axi_req.wvalid && state.rsp.wready) begin
            next_state.w_held = 1'b1;
            next_state.wdata = s_axi_req.wdata;
            next_state.wstrb = s_axi_req.wstrb;
            next_state.rsp.wready = 1'b0;
        end
        if (wr_fire) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.rsp.bvalid = 1'b1;
            next_state.rsp.bresp = wr_known ? sbr_pkg::RESP_OKAY : sbr_pkg::RESP_SLVERR;
            if (state.wstrb[sbr_pkg::BYTE_LANE_BIT]) begin
                unique case (state.awaddr)
                    sbr_pkg::BAUD_CONTROL_1_ADDR: begin
                        next_state.wide = wr_byte[sbr_pkg::WIDE_DIVIDER_BIT];
                    end
                    sbr_pkg::TRANSMIT_STATUS_CONTROL_1_ADDR: begin
                        next_state.sync = wr_byte[sbr_pkg::SYNC_SELECT_BIT];
                        next_state.high_speed = wr_byte[sbr_pkg::HIGH_SPEED_BIT];
                    end
                    sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR: begin
                        next_state.div_low = wr_byte;
                    end
                    sbr_pkg::DIVISOR_HIGH_BYTE_1_ADDR: begin
                        next_state.div_high = wr_byte;
                    end
                    default: begin
                        next_state.div_low = state.div_low;
                    end
                endcase
                // restart so the new rate shows without waiting for the old period
                next_state.clear = wr_divisor;
            end
        end
        if (state.rsp.bvalid && s_axi_req.bready) begin
            next_state.rsp.bvalid = 1'b0;
            next_state.rsp.awready = 1'b1;
            next_state.rsp.wready = 1'b1;
        end
        if (rd_fire) begin
            next_state.rsp.arready = 1'b0;
            next_state.rsp.rvalid = 1'b1;
            next_state.rsp.rdata = {24'h00_0000, rd_byte};
            next_state.rsp.rresp = rd_known ? sbr_pkg::RESP_OKAY : sbr_pkg::RESP_SLVERR;
        end
        if (state.rsp.rvalid && s_axi_req.rready) begin
            next_state.rsp.rvalid = 1'b0;
            next_state.rsp.arready = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state.rsp <= sbr_pkg::AXI_RSP_RESET;
            state.aw_held <= 1'b0;
            state.awaddr <= 32'h0000_0000;
            state.w_held <= 1'b0;
            state.wdata <= 32'h0000_0000;
            state.wstrb <= 4'h0;
            state.wide <= sbr_pkg::WIDE_DIVIDER_RESET;
            state.sync <= sbr_pkg::SYNC_SELECT_RESET;
            state.high_speed <= sbr_pkg::HIGH_SPEED_RESET;
            state.div_low <= sbr_pkg::DIVISOR_BYTE_RESET;
            state.div_high <= sbr_pkg::DIVISOR_BYTE_RESET;
            state.clear <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rate selection
    always_comb begin
        cfg.divisor = {state.div_high, state.div_low};
        cfg.wide = state.wide;
        if (state.sync) begin
            // synchronous clocking never looks at the high speed bit
            cfg.prescale_last = sbr_pkg::PRESCALE_LAST_4;
        end else if (!state.wide) begin
            cfg.prescale_last = state.high_speed ? sbr_pkg::PRESCALE_LAST_16 : sbr_pkg::PRESCALE_LAST_64;
        end else begin
            cfg.prescale_last = state.high_speed ? sbr_pkg::PRESCALE_LAST_4 : sbr_pkg::PRESCALE_LAST_16;
        end
    end

    // one timer serves both framing modes
    sbr_rate_timer u_timer (
        .clock(clock),
        .reset(reset),
        .cfg(cfg),
        .clear(state.clear),
        .tick(bit_tick)
    );

    assign s_axi_rsp = state.rsp;
    assign sync_select = state.sync;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_reset_narrow_mode: assert property ($past(reset) |-> !cfg.wide && cfg.divisor == 16'h0000)
        else $error("timer not narrow after reset");
    a_async_slow_rate: assert property (!state.sync && !state.wide && !state.high_speed |-> cfg.prescale_last == 6'h3F)
        else $error("async narrow slow multiplier wrong");
    a_async_wide_rate: assert property (!state.sync && state.wide && !state.high_speed |-> cfg.prescale_last == 6'h0F)
        else $error("async wide slow multiplier wrong");
    a_async_fast_rate: assert property (!state.sync && state.high_speed |-> cfg.prescale_last == (state.wide ? 6'h03 : 6'h0F))
        else $error("async fast multiplier wrong");
    a_sync_ignores_speed: assert property (state.sync && $past(state.sync) && $stable(state.wide)
        && $changed(state.high_speed) |-> $stable(cfg.prescale_last))
        else $error("sync rate moved with high speed bit");
    a_divisor_write_clear: assert property (wr_fire && wr_divisor && state.wstrb[0] |=> state.clear ##1 !bit_tick)
        else $error("divisor write did not restart timer");
    a_idle_flag_read: assert property (rd_fire && s_axi_req.araddr == 32'h0000_0000 |=> state.rsp.rvalid && state.rsp.rdata[6] == $past(receiver_idle))
        else $error("receiver idle not reported");
    a_bvalid_hold: assert property (state.rsp.bvalid && !s_axi_req.bready |=> state.rsp.bvalid && $stable(state.rsp.bresp))
        else $error("write response dropped early");
    a_read_one_cycle: assert property (rd_fire |=> state.rsp.rvalid ##0 !state.rsp.arready)
        else $error("read answer not one cycle after address");

    c_divisor_write: cover property (wr_fire && wr_divisor ##1 state.clear);
    c_sync_tick: cover property (state.sync && bit_tick);
    c_idle_read: cover property (rd_fire && receiver_idle);

endmodule : sbr_baud_gen
`default_nettype wire

// >>> sbr_pkg.sv
// shared constants and carrier types of the serial baud rate generator
package sbr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses on the bus
    localparam logic [31:0] BAUD_CONTROL_1_ADDR = 32'h0000_0000;
    localparam logic [31:0] TRANSMIT_STATUS_CONTROL_1_ADDR = 32'h0000_0004;
    localparam logic [31:0] DIVISOR_LOW_BYTE_1_ADDR = 32'h0000_0008;
    localparam logic [31:0] DIVISOR_HIGH_BYTE_1_ADDR = 32'h0000_000C;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int RECEIVER_IDLE_BIT = 6;
    localparam int WIDE_DIVIDER_BIT = 3;
    localparam int SYNC_SELECT_BIT = 4;
    localparam int HIGH_SPEED_BIT = 2;
    localparam int BYTE_LANE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic WIDE_DIVIDER_RESET = 1'h0;
    localparam logic SYNC_SELECT_RESET = 1'h0;
    localparam logic HIGH_SPEED_RESET = 1'h0;
    localparam logic [7:0] DIVISOR_BYTE_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler terminal counts: the divider period is multiplied by last + 1
    localparam logic [5:0] PRESCALE_LAST_64 = 6'h3F;
    localparam logic [5:0] PRESCALE_LAST_16 = 6'h0F;
    localparam logic [5:0] PRESCALE_LAST_4 = 6'h03;
    localparam logic [7:0] NARROW_COUNT_MAX = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } sbr_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } sbr_axi_rsp_t;

    localparam sbr_axi_rsp_t AXI_RSP_RESET = '{awready: 1'b1, wready: 1'b1, bresp: RESP_OKAY, bvalid: 1'b0,
                                               arready: 1'b1, rdata: 32'h0000_0000, rresp: RESP_OKAY,
                                               rvalid: 1'b0};

    // settings handed from the register file to the rate timer
    typedef struct packed {
        logic [15:0] divisor;
        logic wide;
        logic [5:0] prescale_last;
    } sbr_rate_cfg_t;

endpackage : sbr_pkg

// >>> sbr_rate_timer.sv
// free running rate divider timer with its period multiplier
`timescale 1ns/10ps
`default_nettype none
module sbr_rate_timer (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // settings
    input wire sbr_pkg::sbr_rate_cfg_t cfg,
    input wire logic clear,
    // tick out
    output logic tick
);

    typedef struct packed {
        logic [15:0] count;
        logic [5:0] prescale;
        logic tick;
    } sbr_timer_state_t;

    sbr_timer_state_t state;
    sbr_timer_state_t next_state;
    logic [15:0] terminal;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // narrow mode: high byte contents play no part
        terminal = cfg.wide ? cfg.divisor : {8'h00, cfg.divisor[7:0]};
        next_state = state;
        next_state.tick = 1'b0;
        if (clear) begin
            next_state.count = 16'h0000;
            next_state.prescale = 6'h00;
        end else if (state.count >= terminal) begin
            // >= so a shrunken terminal never lets the count run to wrap
            next_state.count = 16'h0000;
            if (state.prescale >= cfg.prescale_last) begin
                next_state.prescale = 6'h00;
                next_state.tick = 1'b1;
            end else begin
                next_state.prescale = 6'(state.prescale + 6'h01);
            end
        end else begin
            next_state.count = 16'(state.count + 16'h0001);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

    ////////////////////////////////////////////////////////////////////////////
    // period check helper
    logic [23:0] gap;
    logic armed;
    sbr_pkg::sbr_rate_cfg_t prev_cfg;
    logic [23:0] period;

    // widened before the product: a full wide divisor times 64 needs 23 bits
    assign period = (24'(terminal) + 24'h00_0001) * (24'(cfg.prescale_last) + 24'h00_0001);

    always_ff @(posedge clock) begin
        if (reset) begin
            gap <= 24'h00_0000;
            armed <= 1'b0;
            prev_cfg <= '0;
        end else begin
            prev_cfg <= cfg;
            if (clear || (cfg != prev_cfg)) begin
                gap <= 24'h00_0000;
                armed <= 1'b0;
            end else if (state.tick) begin
                gap <= 24'h00_0000;
                armed <= 1'b1;
            end else begin
                gap <= 24'(gap + 24'h00_0001);
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_tick_period: assert property (state.tick && armed && !clear && cfg == prev_cfg |-> 24'(gap + 24'h00_0001) == period)
        else $error("tick spacing differs from divisor times multiplier");
    a_clear_zeroes_count: assert property (clear |=> state.count == 16'h0000 && state.prescale == 6'h00 && !state.tick)
        else $error("divisor write did not clear the timer");
    a_free_running: assert property (!clear && state.count < terminal |=> state.count == 16'($past(state.count) + 16'h0001))
        else $error("timer did not advance");
    a_narrow_ignores_high: assert property (!cfg.wide && $stable(cfg) |=> state.count <= 16'(sbr_pkg::NARROW_COUNT_MAX))
        else $error("narrow count went past low byte");
    a_wide_wraps_at_pair: assert property (cfg.wide && !clear && state.count == cfg.divisor |=> state.count == 16'h0000)
        else $error("wide count did not wrap at divisor pair");

    c_wide_tick: cover property (cfg.wide && state.tick && armed);
    c_narrow_tick: cover property (!cfg.wide && state.tick && armed);

endmodule : sbr_rate_timer
`default_nettype wire

// >>> sbr_shift_model.sv
// behavioural model of the transceiver shift logic that consumes the bit ticks
`timescale 1ns/10ps
`default_nettype none
module sbr_shift_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // from the rate generator
    input wire logic bit_tick,
    input wire logic sync_select,
    // bench stimulus
    input wire logic rx_start,
    // to the rate generator
    output logic receiver_idle
);
    ////////////////////////////////////////////////////////////////////////////
    // a reception lasts a fixed number of bit ticks; the frame length is a model choice
    logic [3:0] bits_left;

    always_ff @(posedge clock) begin
        if (reset) begin
            bits_left <= 4'h0;
            receiver_idle <= 1'b1;
        end else if (rx_start) begin
            // same tick source in both modes, only the frame length differs
            bits_left <= sync_select ? 4'h8 : 4'hA;
            receiver_idle <= 1'b0;
        end else if (bit_tick && bits_left != 4'h0) begin
            bits_left <= bits_left - 4'h1;
            receiver_idle <= (bits_left == 4'h1);
        end
    end
endmodule : sbr_shift_model
`default_nettype wire

// >>> tb_serial_baud_rate_generator.sv
// self-checking testbench of the serial baud rate generator
`timescale 1ns/10ps
`default_nettype none
module tb_serial_baud_rate_generator;
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
        logic is_read;
    } sbr_exp_t;

    logic clock;
    logic reset;
    logic receiver_idle;
    logic bit_tick;
    logic sync_select;
    logic rx_start;
    sbr_pkg::sbr_axi_req_t req;
    logic [$bits(sbr_pkg::sbr_axi_rsp_t)-1:0] rsp_raw;
    sbr_pkg::sbr_axi_rsp_t rsp;
    sbr_exp_t exp_q[$];
    sbr_exp_t mon_e;
    int failures;
    int n_compared;
    int cycles;
    localparam logic [31:0] IDLE = 32'h0000_0040;
    localparam logic [1:0] OK = sbr_pkg::RESP_OKAY;

    assign rsp = sbr_pkg::sbr_axi_rsp_t'(rsp_raw);

    sbr_baud_gen dut (.clock(clock), .reset(reset), .s_axi_req(req), .s_axi_rsp(rsp_raw),
                      .receiver_idle(receiver_idle), .bit_tick(bit_tick), .sync_select(sync_select));
    sbr_shift_model u_model (.clock(clock), .reset(reset), .bit_tick(bit_tick), .sync_select(sync_select),
                             .rx_start(rx_start), .receiver_idle(receiver_idle));

    ////////////////////////////////////////////////////////////////////////////
    // clock, reset and cycle ceiling
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        reset = 1'b1;
        req = '0;
        rx_start = 1'b0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            failures++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // comparison and closing
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////
    // bus master; holds each channel until its own handshake edge
    task axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        int late;
        exp_q.push_back('{32'h0000_0000, er, 1'b0});
        late = $urandom_range(3, 0);
        n = 0;
        @(posedge clock);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.wvalid <= 1'b1;
        // bready comes zero to three cycles late at random, so with two or three the response has to stand
        forever begin
            @(posedge clock);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1 && req.bready === 1'b1) break;
            if (n == late) req.bready <= 1'b1;
            n++;
        end
        req.bready <= 1'b0;
        check({31'h0, rsp.awready | rsp.wready}, 32'h0, "ready while answering");
    endtask : axi_write

    task axi_read(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        exp_q.push_back('{d, er, 1'b1});
        @(posedge clock);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) break;
        end
        req.rready <= 1'b0;
        check({31'h0, rsp.arready}, 32'h0, "arready while answering");
    endtask : axi_read

    // byte write with random junk in the unused upper bits
    task wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        r = $urandom();
        axi_write(a, {r[31:8], d}, 4'h1, OK);
    endtask : wr

    // answers are taken off the queue in the order they were noted
    always @(posedge clock) begin
        if (!reset && rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
            mon_e = exp_q.pop_front();
            check({31'h0, mon_e.is_read}, 32'h1, "read order");
            check(rsp.rdata, mon_e.data, "rdata");
            check({30'h0, rsp.rresp}, {30'h0, mon_e.resp}, "rresp");
        end
        if (!reset && rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
            mon_e = exp_q.pop_front();
            check({31'h0, mon_e.is_read}, 32'h0, "write order");
            check({30'h0, rsp.bresp}, {30'h0, mon_e.resp}, "bresp");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tick period measurement
    task wait_tick;
        int n;
        for (n = 0; n < 20000; n++) begin
            @(posedge clock);
            if (bit_tick === 1'b1) break;
        end
    endtask : wait_tick

    task period(input int exp, input string what);
        int c;
        wait_tick();
        for (c = 1; c < 20000; c++) begin
            @(posedge clock);
            if (bit_tick === 1'b1) break;
        end
        check(c, exp, what);
    endtask : period

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int i;
        int m;
        int t;
        int c;
        logic [7:0] lo;
        logic s;
        logic w;
        logic h;
        void'($urandom(32'h0126));
        repeat (22) @(posedge clock);
        axi_read(sbr_pkg::BAUD_CONTROL_1_ADDR, IDLE, OK);
        axi_read(sbr_pkg::TRANSMIT_STATUS_CONTROL_1_ADDR, 32'h0, OK);
        axi_read(sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR, 32'h0, OK);
        axi_read(sbr_pkg::DIVISOR_HIGH_BYTE_1_ADDR, 32'h0, OK);
        period(64, "reset period");
        // every mode; the high byte is set so narrow modes must ignore it
        for (i = 0; i < 8; i++) begin
            s = i[2];
            w = i[1];
            h = i[0];
            lo = 8'($urandom_range(7, 0));
            m = s ? 4 : (w ? (h ? 4 : 16) : (h ? 16 : 64));
            t = w ? 256 + int'(lo) : int'(lo);
            wr(sbr_pkg::BAUD_CONTROL_1_ADDR, 8'({w, 3'h0}));
            wr(sbr_pkg::TRANSMIT_STATUS_CONTROL_1_ADDR, 8'({s, 1'b0, h, 2'h0}));
            wr(sbr_pkg::DIVISOR_HIGH_BYTE_1_ADDR, 8'h01);
            wr(sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR, lo);
            axi_read(sbr_pkg::BAUD_CONTROL_1_ADDR, IDLE | 32'({w, 3'h0}), OK);
            axi_read(sbr_pkg::TRANSMIT_STATUS_CONTROL_1_ADDR, 32'({s, 1'b0, h, 2'h0}), OK);
            axi_read(sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR, 32'(lo), OK);
            check({31'h0, sync_select}, {31'h0, s}, "sync select");
            period((t + 1) * m, "mode period");
        end
        // divisor write in mid-period restarts the count
        wr(sbr_pkg::BAUD_CONTROL_1_ADDR, 8'h00);
        wr(sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR, 8'h09);
        period(40, "sync narrow period");
        repeat (5) @(posedge clock);
        wr(sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR, 8'h03);
        for (c = 1; c < 100; c++) begin
            @(posedge clock);
            if (bit_tick === 1'b1) break;
        end
        check({31'h0, c >= 14 && c <= 18}, 32'h1, "tick after divisor write");
        // refused writes and unmapped places
        axi_write(sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR, 32'h0000_00AA, 4'h0, OK);
        axi_read(sbr_pkg::DIVISOR_LOW_BYTE_1_ADDR, 32'h3, OK);
        axi_write(32'h0000_0010, 32'h0000_00FF, 4'hF, sbr_pkg::RESP_SLVERR);
        axi_read(32'h0000_0010, 32'h0, sbr_pkg::RESP_SLVERR);
        // software waits for the receiver to go idle before touching the clock
        @(posedge clock);
        rx_start <= 1'b1;
        @(posedge clock);
        rx_start <= 1'b0;
        axi_read(sbr_pkg::BAUD_CONTROL_1_ADDR, 32'h0, OK);
        for (c = 0; c < 2000 && receiver_idle !== 1'b1; c++) @(posedge clock);
        axi_read(sbr_pkg::BAUD_CONTROL_1_ADDR, IDLE, OK);
        repeat (5) @(posedge clock);
        check(exp_q.size(), 32'h0, "answers outstanding");
        end_sim();
    end
endmodule : tb_serial_baud_rate_generator
`default_nettype wire
